// file: logic/src_pkg.sv
package src_pkg;
    // ==================================================
    // register offsets
    localparam logic [7:0] OFS_SYNTH_CFG0 = 8'h9F;
    localparam logic [7:0] OFS_SYNTH_CFG1 = 8'h9E;
    localparam logic [7:0] OFS_ANA_FUNC0  = 8'h01;
    localparam logic [7:0] OFS_ANA_FUNC1  = 8'h00;
    localparam logic [7:0] OFS_OSC_CFG    = 8'h21;
    localparam logic [7:0] OFS_OSC_TEST   = 8'hB4;
    localparam logic [7:0] OFS_PROTO2     = 8'h50;
    localparam logic [7:0] OFS_CAL_IN0    = 8'h6F;
    localparam logic [7:0] OFS_CAL_IN1    = 8'h6E;
    localparam logic [7:0] OFS_CAL_OUT0   = 8'hE5;
    localparam logic [7:0] OFS_CAL_OUT1   = 8'hE4;
    localparam logic [7:0] OFS_TX_CTRL    = 8'h1A;
    localparam logic [7:0] OFS_STATUS     = 8'hC1;
    // ==================================================
    // field positions
    localparam int BIT_SPLIT   = 7;
    localparam int BIT_REF_DIV2_EN  = 7;
    localparam int BIT_XSEL    = 6;
    localparam int BIT_BROWN   = 2;
    localparam int BIT_LEVEL   = 1;
    localparam int BIT_EXTRC   = 3;
    localparam int BIT_CLKPD   = 3;
    localparam int BIT_RCOCAL  = 0;
    localparam int BIT_VCOAUTO = 1;
    localparam int BIT_CW      = 0;
    // ==================================================
    // reset values
    localparam logic [7:0] RST_OSC_TEST = 8'h08;
    localparam logic [7:0] RST_PROTO2   = 8'h02;
    localparam logic [7:0] RST_CAL_IN0  = 8'h48;
    localparam logic [7:0] RST_CAL_IN1  = 8'h11;
    localparam logic [7:0] RST_GENERIC  = 8'h00;
    // ==================================================
    // commands
    localparam logic [7:0] CMD_PREFIX  = 8'h80;
    localparam logic [7:0] CMD_TX      = 8'h60;
    localparam logic [7:0] CMD_READY   = 8'h62;
    localparam logic [7:0] CMD_STANDBY = 8'h63;
    localparam logic [7:0] CMD_LOCK_FOR_TRANSMIT_CMD  = 8'h66;
    localparam logic [7:0] CMD_SABORT  = 8'h67;
    // ==================================================
    // timing
    localparam int CLK_MHZ        = 200;
    localparam int T_VCOCAL_US    = 54;
    localparam int T_LOCK_AUTO_US = 80;
    localparam int T_LOCK_PRE_US  = 20;
    localparam int CYC_VCOCAL     = T_VCOCAL_US * CLK_MHZ;
    localparam int CYC_LOCK_AUTO  = T_LOCK_AUTO_US * CLK_MHZ;
    localparam int CYC_LOCK_PRE   = T_LOCK_PRE_US * CLK_MHZ;
    localparam int RCO_DIV_24     = 692;
    localparam int RCO_DIV_26     = 750;
    localparam int RAMP_STEPS     = 8;
    localparam int RAMP_STEP_CYC  = 16;
    typedef enum logic [2:0] {ST_STANDBY, ST_READY, ST_CAL, ST_LOCKING,
                              ST_LOCK, ST_RAMPUP, ST_TX, ST_RAMPDN} src_state_e;
endpackage

// file: logic/src_clock_config.sv
`timescale 1ns/1ps
module src_clock_config
    import src_pkg::*;
#(
    parameter int LOCK_AUTO_CYC = CYC_LOCK_AUTO,
    parameter int LOCK_PRE_CYC  = CYC_LOCK_PRE,
    parameter int VCOCAL_CYC    = CYC_VCOCAL
)(
    input  wire logic       mclk,          // system clock
    input  wire logic       reset_n,       // async reset
    input  wire logic       cmd_valid,     // command byte pulse
    input  wire logic [7:0] cmd_byte,      // command frame byte
    input  wire logic       reg_wr,        // register write pulse
    input  wire logic [7:0] reg_addr,      // register address
    input  wire logic [7:0] reg_wdata,     // write data
    output logic      [7:0] reg_rdata,     // read data
    input  wire logic       xo_clk,        // crystal clock, sampled
    input  wire logic       ref_clk_in,    // synthesizer reference in
    input  wire logic       rco_clk,       // slow oscillator, sampled
    input  wire logic [4:0] vco_cal_meas,  // calibration engine result
    input  wire logic       brownout_in,   // brownout comparator
    input  wire logic       level_det_in,  // level comparator
    input  wire logic       tx_done,       // packet finished
    output logic            dig_clk_q,     // digital clock
    output logic            ref_clk_q,     // synthesizer reference
    output logic [2:0]      xo_startup_gain, // crystal gain code
    output logic [4:0]      vco_word_q,    // applied vco word
    output logic [3:0]      coarse_trim_q, // applied coarse trim
    output logic [4:0]      fine_trim_q,   // applied fine trim
    output logic            slow_clk_ext,  // external slow clock select
    output logic            batt_warn_q,   // early warning, no reset
    output logic [2:0]      pa_level_q,    // amplifier ramp level
    output logic            cw_mode,       // unmodulated carrier
    output src_state_e      state_q        // operating state
);
    if (LOCK_AUTO_CYC < 1 || LOCK_PRE_CYC < 1 || VCOCAL_CYC < 1 ||
        LOCK_AUTO_CYC > 65535 || LOCK_PRE_CYC > 65535 || VCOCAL_CYC > 65535)
    begin : g_bad_count
        $error("counts must fit the 16-bit timer");
    end
    // ==================================================
    // registers
    logic [7:0] synth0_q, synth1_q, ana0_q, ana1_q, osccfg_q, osctest_q;
    logic [7:0] proto2_q, calin0_q, calin1_q, txctl_q;
    logic [4:0] vco_out_q, fine_out_q;
    logic [3:0] coarse_out_q;
    logic       prefix_q, clkdiv_eff_q, ref_div2_en_eff_q, busy;
    assign busy = (state_q != ST_STANDBY) && (state_q != ST_READY);
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            synth0_q  <= RST_GENERIC;
            synth1_q  <= RST_GENERIC;
            ana0_q    <= RST_GENERIC;
            ana1_q    <= RST_GENERIC;
            osccfg_q  <= RST_GENERIC;
            osctest_q <= RST_OSC_TEST;
            proto2_q  <= RST_PROTO2;
            calin0_q  <= RST_CAL_IN0;
            calin1_q  <= RST_CAL_IN1;
            txctl_q   <= RST_GENERIC;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_SYNTH_CFG0)
                synth0_q <= reg_wdata;
            else if (reg_addr == OFS_SYNTH_CFG1)
                synth1_q <= reg_wdata;
            else if (reg_addr == OFS_ANA_FUNC0)
                ana0_q <= reg_wdata;
            else if (reg_addr == OFS_ANA_FUNC1)
                ana1_q <= reg_wdata;
            else if (reg_addr == OFS_OSC_CFG)
                osccfg_q <= reg_wdata;
            else if (reg_addr == OFS_OSC_TEST)
                osctest_q <= reg_wdata;
            else if (reg_addr == OFS_PROTO2)
                proto2_q <= reg_wdata;
            else if (reg_addr == OFS_CAL_IN0)
                calin0_q <= reg_wdata;
            else if (reg_addr == OFS_CAL_IN1)
                calin1_q <= reg_wdata;
            else if (reg_addr == OFS_TX_CTRL)
                txctl_q <= reg_wdata;
        end
    end
    always_comb
    begin
        if (reg_addr == OFS_SYNTH_CFG0)
            reg_rdata = synth0_q;
        else if (reg_addr == OFS_SYNTH_CFG1)
            reg_rdata = synth1_q;
        else if (reg_addr == OFS_ANA_FUNC0)
            reg_rdata = ana0_q;
        else if (reg_addr == OFS_ANA_FUNC1)
            reg_rdata = ana1_q;
        else if (reg_addr == OFS_OSC_CFG)
            reg_rdata = osccfg_q;
        else if (reg_addr == OFS_OSC_TEST)
            reg_rdata = osctest_q;
        else if (reg_addr == OFS_PROTO2)
            reg_rdata = proto2_q;
        else if (reg_addr == OFS_CAL_IN0)
            reg_rdata = calin0_q;
        else if (reg_addr == OFS_CAL_IN1)
            reg_rdata = calin1_q;
        else if (reg_addr == OFS_TX_CTRL)
            reg_rdata = txctl_q;
        else if (reg_addr == OFS_CAL_OUT0)
            reg_rdata = {3'h0, vco_out_q};
        else if (reg_addr == OFS_CAL_OUT1)
            reg_rdata = {coarse_out_q, fine_out_q[3:0]};
        else if (reg_addr == OFS_STATUS)
            reg_rdata = {batt_warn_q, 4'h0, state_q};
        else
            reg_rdata = 8'h00;
    end
    assign xo_startup_gain = ana1_q[2:0];
    assign slow_clk_ext    = osccfg_q[BIT_EXTRC];
    assign cw_mode         = txctl_q[BIT_CW];
    // ==================================================
    // divider settings latched only while idle
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clkdiv_eff_q <= 1'b1;
            ref_div2_en_eff_q <= 1'b0;
        end
        else if (!busy)
        begin
            clkdiv_eff_q <= osctest_q[BIT_CLKPD];
            ref_div2_en_eff_q <= synth1_q[BIT_REF_DIV2_EN];
        end
    end
    // ==================================================
    // clock dividers: crystal rising edges detected when dividing, level passed through when undivided
    logic xo_prev_q, ref_prev_q, rco_prev_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xo_prev_q  <= 1'b0;
            ref_prev_q <= 1'b0;
            dig_clk_q  <= 1'b0;
            ref_clk_q  <= 1'b0;
        end
        else
        begin
            xo_prev_q  <= xo_clk;
            ref_prev_q <= ref_clk_in;
            if (clkdiv_eff_q)
            begin
                if (xo_clk && !xo_prev_q)
                    dig_clk_q <= ~dig_clk_q;
            end
            else
                dig_clk_q <= xo_clk;
            if (ref_div2_en_eff_q)
            begin
                if (ref_clk_in && !ref_prev_q)
                    ref_clk_q <= ~ref_clk_q;
            end
            else
                ref_clk_q <= ref_clk_in;
        end
    end
    // ==================================================
    // synthesizer state machine
    logic [15:0] tmr_q;
    logic [2:0]  ramp_q;
    logic [4:0]  step_q;
    logic        auto_cal, tx_req_q;
    assign auto_cal = proto2_q[BIT_VCOAUTO];
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            prefix_q <= 1'b0;
        else if (cmd_valid)
            prefix_q <= (cmd_byte == CMD_PREFIX) && !prefix_q;
    end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q   <= ST_READY;
            tmr_q     <= 16'h0000;
            tx_req_q  <= 1'b0;
            ramp_q    <= 3'h0;
            step_q    <= 5'h00;
            vco_word_q <= 5'h00;
            vco_out_q  <= 5'h00;
        end
        else
        begin
            tmr_q <= tmr_q + 16'h0001;
            case (state_q)
                ST_STANDBY:
                    if (cmd_valid && prefix_q && cmd_byte == CMD_READY)
                        state_q <= ST_READY;
                ST_READY:
                    if (cmd_valid && prefix_q)
                    begin
                        if (cmd_byte == CMD_STANDBY)
                            state_q <= ST_STANDBY;
                        else if (cmd_byte == CMD_LOCK_FOR_TRANSMIT_CMD || cmd_byte == CMD_TX)
                        begin
                            tx_req_q <= (cmd_byte == CMD_TX);
                            tmr_q    <= 16'h0000;
                            if (auto_cal)
                                state_q <= ST_CAL;
                            else
                            begin
                                vco_word_q <= calin0_q[4:0];
                                state_q    <= ST_LOCKING;
                            end
                        end
                    end
                ST_CAL:
                    if (tmr_q == 16'(VCOCAL_CYC - 1))
                    begin
                        vco_word_q <= vco_cal_meas;
                        vco_out_q  <= vco_cal_meas;
                    end
                    else if (tmr_q >= 16'(VCOCAL_CYC))
                        state_q <= ST_LOCKING;
                ST_LOCKING:
                    if (tmr_q >= 16'(auto_cal ? LOCK_AUTO_CYC : LOCK_PRE_CYC))
                    begin
                        state_q <= tx_req_q ? ST_RAMPUP : ST_LOCK;
                        step_q  <= 5'h00;
                    end
                ST_LOCK:
                    if (cmd_valid && prefix_q && cmd_byte == CMD_READY)
                        state_q <= ST_READY;
                    else if (cmd_valid && prefix_q && cmd_byte == CMD_TX)
                        state_q <= ST_RAMPUP;
                ST_RAMPUP:
                begin
                    step_q <= step_q + 5'h01;
                    if (step_q == 5'(RAMP_STEP_CYC - 1))
                    begin
                        step_q <= 5'h00;
                        if (ramp_q == 3'(RAMP_STEPS - 1))
                            state_q <= ST_TX;
                        else
                            ramp_q <= ramp_q + 3'h1;
                    end
                end
                ST_TX:
                    if (tx_done || (cmd_valid && prefix_q && cmd_byte == CMD_SABORT))
                        state_q <= ST_RAMPDN;
                ST_RAMPDN:
                begin
                    step_q <= step_q + 5'h01;
                    if (step_q == 5'(RAMP_STEP_CYC - 1))
                    begin
                        step_q <= 5'h00;
                        if (ramp_q == 3'h0)
                            state_q <= ST_READY;
                        else
                            ramp_q <= ramp_q - 3'h1;
                    end
                end
                default:
                    state_q <= ST_READY;
            endcase
        end
    end
    assign pa_level_q = ramp_q;
    // ==================================================
    // slow oscillator calibration: count rco periods per reference window
    logic [9:0]  ref_cnt_q, rco_cnt_q;
    logic [9:0]  ref_div;
    assign ref_div = ana0_q[BIT_XSEL] ? 10'(RCO_DIV_26) : 10'(RCO_DIV_24);
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_cnt_q    <= 10'h000;
            rco_cnt_q    <= 10'h000;
            rco_prev_q   <= 1'b0;
            coarse_out_q <= 4'h0;
            fine_out_q   <= 5'h01;
        end
        else
        begin
            rco_prev_q <= rco_clk;
            if (proto2_q[BIT_RCOCAL])
            begin
                if (rco_clk && !rco_prev_q)
                    rco_cnt_q <= rco_cnt_q + 10'h001;
                if (dig_clk_q && ref_cnt_q == ref_div - 10'h001)
                begin
                    ref_cnt_q <= 10'h000;
                    rco_cnt_q <= 10'h000;
                    // more than one slow edge per window: too fast, trim down
                    if (rco_cnt_q > 10'h001 && fine_out_q > 5'h01)
                        fine_out_q <= fine_out_q - 5'h01;
                    else if (rco_cnt_q == 10'h000 && fine_out_q < 5'h1F)
                        fine_out_q <= fine_out_q + 5'h01;
                end
                else
                    ref_cnt_q <= ref_cnt_q + 10'h001;
            end
        end
    end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            coarse_trim_q <= 4'h0;
            fine_trim_q   <= 5'h01;
        end
        else if (proto2_q[BIT_RCOCAL])
        begin
            coarse_trim_q <= coarse_out_q;
            fine_trim_q   <= fine_out_q;
        end
        else
        begin
            coarse_trim_q <= calin1_q[7:4];
            fine_trim_q   <= calin1_q[4:0];
        end
    end
    // ==================================================
    // battery warning: independent of state, flag only
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            batt_warn_q <= 1'b0;
        else
            batt_warn_q <= (ana0_q[BIT_BROWN] & brownout_in)
                         | (ana0_q[BIT_LEVEL] & level_det_in);
    end
endmodule

// file: dv/src_clock_config_assertions.sv
`timescale 1ns/1ps
// ==================================================
// port checker
module src_clock_config_assertions
    import src_pkg::*;
#(
    parameter int LOCK_AUTO_CYC = 60,
    parameter int LOCK_PRE_CYC  = 30,
    parameter int VCOCAL_CYC    = 20
)(
    input wire logic       mclk,          // clock
    input wire logic       reset_n,       // async reset
    input wire logic       cmd_valid,     // command strobe
    input wire logic [7:0] cmd_byte,      // command byte
    input wire logic       reg_wr,        // write strobe
    input wire logic [7:0] reg_addr,      // address
    input wire logic [7:0] reg_wdata,     // write data
    input wire logic [4:0] vco_cal_meas,  // engine result
    input wire logic       brownout_in,   // brownout level
    input wire logic [4:0] vco_word_q,    // applied vco word
    input wire logic [3:0] coarse_trim_q, // coarse trim
    input wire logic [4:0] fine_trim_q,   // fine trim
    input wire logic       batt_warn_q,   // warning flag
    input wire logic [2:0] pa_level_q,    // ramp level
    input wire src_state_e state_q        // state
);
    localparam int CAL_LO = VCOCAL_CYC - 10;
    localparam int CAL_HI = VCOCAL_CYC - 5;
    localparam int PRE_LO = LOCK_PRE_CYC - 2;
    localparam int PRE_HI = LOCK_PRE_CYC + 3;
    localparam int AUT_LO = LOCK_AUTO_CYC - 2;
    localparam int AUT_HI = LOCK_AUTO_CYC + 3;
    logic       pfx_q;
    logic       auto_q;
    logic       rco_q;
    logic       brn_q;
    logic [7:0] cin1_q;
    logic       lock_cmd;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // ==================================================
    // shadows of what the host wrote
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            pfx_q <= 1'b0;
        else if (cmd_valid)
            pfx_q <= (cmd_byte == CMD_PREFIX);
    end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            auto_q <= RST_PROTO2[BIT_VCOAUTO];
            rco_q  <= RST_PROTO2[BIT_RCOCAL];
            cin1_q <= RST_CAL_IN1;
            brn_q  <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_PROTO2)
            begin
                auto_q <= reg_wdata[BIT_VCOAUTO];
                rco_q  <= reg_wdata[BIT_RCOCAL];
            end
            if (reg_addr == OFS_CAL_IN1)
                cin1_q <= reg_wdata;
            if (reg_addr == OFS_ANA_FUNC0)
                brn_q <= reg_wdata[BIT_BROWN];
        end
    end
    assign lock_cmd = cmd_valid && pfx_q && cmd_byte == CMD_LOCK_FOR_TRANSMIT_CMD && state_q == ST_READY;
    // ==================================================
    // properties
    a_auto_cal: assert property (p_auto_cal)
        else $error("lock request did not start calibration");
    property p_auto_cal;
        lock_cmd && auto_q |=> state_q == ST_CAL;
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
    property p_cal_len;
        $rose(state_q == ST_CAL) |-> (state_q == ST_CAL) [*8] ##[CAL_LO:CAL_HI]
            state_q == ST_LOCKING;
    endproperty
    a_vco_apply: assert property (p_vco_apply)
        else $error("calibration word not applied");
    property p_vco_apply;
        state_q == ST_CAL ##1 state_q == ST_LOCKING |-> ##[0:1] vco_word_q == vco_cal_meas;
    endproperty
    a_preload: assert property (p_preload)
        else $error("preloaded lock ran calibration");
    property p_preload;
        lock_cmd && !auto_q |=> state_q == ST_LOCKING;
    endproperty
    a_lock_pre: assert property (p_lock_pre)
        else $error("preloaded lock time wrong");
    property p_lock_pre;
        lock_cmd && !auto_q |-> ##[PRE_LO:PRE_HI] state_q == ST_LOCK;
    endproperty
    a_lock_auto: assert property (p_lock_auto)
        else $error("calibrated lock time wrong");
    property p_lock_auto;
        lock_cmd && auto_q |-> ##[AUT_LO:AUT_HI] state_q == ST_LOCK;
    endproperty
    a_trim_in: assert property (p_trim_in)
        else $error("trim does not follow input words");
    property p_trim_in;
        !rco_q && !reg_wr && !$past(reg_wr) && $past(reset_n, 2) |->
            coarse_trim_q == cin1_q[7:4] && fine_trim_q == cin1_q[4:0];
    endproperty
    a_warn: assert property (p_warn)
        else $error("brownout not flagged");
    property p_warn;
        (brn_q && brownout_in) [*2] |-> ##[0:2] batt_warn_q;
    endproperty
    a_warn_state: assert property (p_warn_state)
        else $error("warning disturbed state");
    property p_warn_state;
        $rose(batt_warn_q) |-> state_q == $past(state_q);
    endproperty
    a_ramp_up: assert property (p_ramp_up)
        else $error("ramp up went down");
    property p_ramp_up;
        state_q == ST_RAMPUP |=> pa_level_q >= $past(pa_level_q);
    endproperty
    a_ramp_dn: assert property (p_ramp_dn)
        else $error("ramp down went up");
    property p_ramp_dn;
        state_q == ST_RAMPDN |=> pa_level_q <= $past(pa_level_q);
    endproperty
endmodule

// file: dv/src_host_model.sv
`timescale 1ns/1ps
// ==================================================
// host controller driving the register port
module src_host_model
    import src_pkg::*;
(
    input  wire logic       mclk,      // clock
    input  wire logic [7:0] reg_rdata, // read data
    output logic            cmd_valid, // command strobe
    output logic      [7:0] cmd_byte,  // command byte
    output logic            reg_wr,    // write strobe
    output logic      [7:0] reg_addr,  // address
    output logic      [7:0] reg_wdata  // write data
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // released lines flip so stale data never looks valid
    task automatic raw(input logic [7:0] b);
        @(negedge mclk);
        cmd_byte  = b;
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_byte  = ~b;
    endtask
    task automatic cmd(input logic [7:0] c);
        raw(CMD_PREFIX);
        raw(c);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        @(posedge mclk);
        d = reg_rdata;
    endtask
    task automatic div_off();
        cmd(CMD_STANDBY);
        wr(OFS_OSC_TEST, 8'h00);
        cmd(CMD_READY);
    endtask
    task automatic ext_sel();
        wr(OFS_OSC_CFG, 8'h08);
        wr(OFS_PROTO2, 8'h02);
    endtask
    task automatic split_max();
        wr(OFS_SYNTH_CFG0, 8'h80);
    endtask
endmodule

// file: dv/src_clock_config_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("Error %s expected %0h seen %0h", n, e, g); \
        end \
    end
module src_clock_config_tb
    import src_pkg::*;
;
    localparam int AUTO = 60;
    localparam int PRE  = 30;
    localparam int VCAL = 20;
    logic       mclk, reset_n, cmd_valid, reg_wr, xo_clk, ref_clk_in, rco_clk;
    logic       brownout_in, level_det_in, tx_done, dig_clk_q, ref_clk_q;
    logic       slow_clk_ext, batt_warn_q, cw_mode;
    logic [7:0] cmd_byte, reg_addr, reg_wdata, reg_rdata, d;
    logic [4:0] vco_cal_meas, vco_word_q, fine_trim_q;
    logic [3:0] coarse_trim_q;
    logic [2:0] xo_startup_gain, pa_level_q;
    src_state_e state_q;
    int         err_total, num_checks, dig_n, ref_n;
    src_clock_config #(.LOCK_AUTO_CYC(AUTO), .LOCK_PRE_CYC(PRE), .VCOCAL_CYC(VCAL))
        src_clock_config_inst (.mclk, .reset_n, .cmd_valid, .cmd_byte, .reg_wr, .reg_addr,
        .reg_wdata, .reg_rdata, .xo_clk, .ref_clk_in, .rco_clk, .vco_cal_meas, .brownout_in,
        .level_det_in, .tx_done, .dig_clk_q, .ref_clk_q, .xo_startup_gain, .vco_word_q,
        .coarse_trim_q, .fine_trim_q, .slow_clk_ext, .batt_warn_q, .pa_level_q, .cw_mode,
        .state_q);
    src_host_model host_inst (.mclk, .reg_rdata, .cmd_valid, .cmd_byte, .reg_wr, .reg_addr,
        .reg_wdata);
    // ==================================================
    // clocks and edge counters
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(negedge mclk)
    begin
        xo_clk     <= ~xo_clk;
        ref_clk_in <= ~ref_clk_in;
        rco_clk    <= ~rco_clk;
    end
    always @(posedge dig_clk_q) dig_n++;
    always @(posedge ref_clk_q) ref_n++;
    // ==================================================
    // helpers
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic meas(input int ed, input int er);
        int d0;
        int r0;
        repeat (2) @(posedge mclk);
        #1;
        d0 = dig_n;
        r0 = ref_n;
        repeat (16) @(posedge mclk);
        #1;
        `CHK("dig_rises", ed, dig_n - d0)
        `CHK("ref_rises", er, ref_n - r0)
    endtask
    task automatic wait_st(input src_state_e s, input int lim);
        int k;
        k = 0;
        while (state_q !== s && k < lim)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        `CHK("state", s, state_q)
    endtask
    // ==================================================
    // tests
    initial
    begin
        {reset_n, brownout_in, level_det_in, tx_done, xo_clk, ref_clk_in, rco_clk} = 7'h00;
        vco_cal_meas = 5'h0B;
        err_total = 0;
        num_checks = 0;
        dig_n = 0;
        ref_n = 0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        host_inst.rd(OFS_OSC_TEST, d);
        `CHK("osc_test", RST_OSC_TEST, d)
        host_inst.rd(OFS_PROTO2, d);
        `CHK("proto2", RST_PROTO2, d)
        host_inst.rd(8'h77, d);
        `CHK("unmapped", 8'h00, d)
        host_inst.split_max();
        host_inst.rd(OFS_SYNTH_CFG0, d);
        `CHK("reg_a_low", 8'h80, d)
        `CHK("coarse", 4'h1, coarse_trim_q)
        `CHK("fine", 5'h11, fine_trim_q)
        meas(4, 8);
        host_inst.wr(OFS_SYNTH_CFG1, 8'h80);
        meas(4, 4);
        host_inst.wr(OFS_SYNTH_CFG1, 8'h00);
        for (int g = 0; g < 8; g++)
        begin
            host_inst.wr(OFS_ANA_FUNC1, 8'(g));
            `CHK("gain", 3'(g), xo_startup_gain)
        end
        host_inst.ext_sel();
        `CHK("ext_slow", 1'b1, slow_clk_ext)
        host_inst.wr(OFS_CAL_IN1, 8'hD5);
        repeat (2) @(posedge mclk);
        `CHK("coarse", 4'hD, coarse_trim_q)
        `CHK("fine", 5'h15, fine_trim_q)
        host_inst.raw(CMD_LOCK_FOR_TRANSMIT_CMD);
        `CHK("state", ST_READY, state_q)
        host_inst.cmd(CMD_LOCK_FOR_TRANSMIT_CMD);
        wait_st(ST_CAL, 3);
        wait_st(ST_LOCKING, 30);
        `CHK("vco", 5'h0B, vco_word_q)
        host_inst.rd(OFS_CAL_OUT0, d);
        `CHK("cal_out", 8'h0B, d)
        host_inst.rd(OFS_CAL_OUT1, d);
        `CHK("cal_out1", 8'h01, d)
        wait_st(ST_LOCK, 80);
        host_inst.wr(OFS_OSC_TEST, 8'h00);
        meas(4, 8);
        host_inst.wr(OFS_OSC_TEST, 8'h08);
        host_inst.cmd(CMD_READY);
        wait_st(ST_READY, 4);
        host_inst.div_off();
        wait_st(ST_READY, 4);
        meas(8, 8);
        host_inst.wr(OFS_PROTO2, 8'h00);
        host_inst.wr(OFS_CAL_IN0, 8'h0A);
        host_inst.cmd(CMD_LOCK_FOR_TRANSMIT_CMD);
        wait_st(ST_LOCKING, 3);
        `CHK("vco", 5'h0A, vco_word_q)
        wait_st(ST_LOCK, 40);
        host_inst.cmd(CMD_READY);
        wait_st(ST_READY, 4);
        host_inst.wr(OFS_TX_CTRL, 8'h01);
        `CHK("cw", 1'b1, cw_mode)
        host_inst.cmd(CMD_TX);
        wait_st(ST_TX, 400);
        `CHK("pa_on", 1'b1, pa_level_q != 3'h0)
        @(negedge mclk);
        tx_done = 1'b1;
        @(negedge mclk);
        tx_done = 1'b0;
        wait_st(ST_READY, 400);
        `CHK("pa_off", 3'h0, pa_level_q)
        host_inst.wr(OFS_ANA_FUNC0, 8'h04);
        host_inst.cmd(CMD_STANDBY);
        wait_st(ST_STANDBY, 4);
        @(negedge mclk);
        brownout_in = 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("warn", 1'b1, batt_warn_q)
        `CHK("state", ST_STANDBY, state_q)
        results();
    end
    initial
    begin
        #100000;
        err_total++;
        results();
    end
endmodule
bind src_clock_config src_clock_config_assertions #(.LOCK_AUTO_CYC(LOCK_AUTO_CYC),
    .LOCK_PRE_CYC(LOCK_PRE_CYC), .VCOCAL_CYC(VCOCAL_CYC)) chk_inst (.mclk, .reset_n,
    .cmd_valid, .cmd_byte, .reg_wr, .reg_addr, .reg_wdata, .vco_cal_meas, .brownout_in,
    .vco_word_q, .coarse_trim_q, .fine_trim_q, .batt_warn_q, .pa_level_q, .state_q);
